// ===== src/mcp_pwm_out.sv
// Multi-channel PWM output generator with a classic Wishbone register slave.
`timescale 1ns/1ps
`include "mcp_cfg.svh"
module mcp_pwm_out #(
	parameter int unsigned TICK_CYCLES = `MCP_MS_CYCLES
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic wdTimeout,
	output mcp_pkg::mcp_chan_t doOut
);
	import mcp_pkg::*;

	localparam mcp_state_t RST_STATE = '{
		pwmEn: 1'b0,
		alarmEn: 1'b0,
		doLevel: '0,
		hiTime: {`MCP_NCH{`MCP_TIME_RST}},
		loTime: {`MCP_NCH{`MCP_TIME_RST}},
		cnt: {`MCP_NCH{`MCP_TIME_RST}},
		phase: '1,
		out: '0,
		ack: 1'b0,
		rdat: '0
	};

	mcp_state_t stQ;
	mcp_state_t stD;
	logic msTick;
	logic running;
	mcp_chan_t chActive;
	logic busReq;
	logic busWrite;
	logic timeSel;
	logic [2:0] timeIdx;

	mcp_tick_div #(
		.CYCLES(TICK_CYCLES)
	) u_tick (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.tick(msTick)
	);

	// Merge byte lanes into a 32-bit old value.
	function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// Values 1 to 4 are below the usable range and are raised to the minimum; zero is kept.
	function automatic mcp_time_t timeClamp(input mcp_time_t v);
		if (v != '0 && v < `MCP_TIME_MIN) begin
			return `MCP_TIME_MIN;
		end
		return v;
	endfunction

	assign running = stQ.pwmEn | (stQ.alarmEn & wdTimeout);
	assign busReq = wb_cyc_i & wb_stb_i;
	// Writes land on the edge where the master sees ack, so the master's view and ours agree.
	assign busWrite = busReq & wb_we_i & stQ.ack;
	assign timeSel = (wb_adr_i[7:5] == `MCP_TIME_PAGE);
	assign timeIdx = wb_adr_i[4:2];

	always_comb begin
		logic [31:0] tw;
		tw = '0;
		stD = stQ;
		stD.ack = busReq & ~stQ.ack;
		for (int i = 0; i < `MCP_NCH; i++) begin
			chActive[i] = running && stQ.hiTime[i] != '0 && stQ.loTime[i] != '0;
		end
		stD.rdat = '0;
		if (busReq & ~stQ.ack & ~wb_we_i) begin
			if (timeSel) begin
				stD.rdat[`MCP_HI_LSB +: `MCP_TW] = stQ.hiTime[timeIdx];
				stD.rdat[`MCP_LO_LSB +: `MCP_TW] = stQ.loTime[timeIdx];
			end else begin
				case (wb_adr_i)
					`MCP_ADR_CTRL: begin
						stD.rdat[`MCP_CTRL_PWM] = stQ.pwmEn;
						stD.rdat[`MCP_CTRL_ALARM] = stQ.alarmEn;
					end
					`MCP_ADR_STAT: begin
						stD.rdat[`MCP_NCH-1:0] = stQ.out;
						stD.rdat[`MCP_STAT_ACT_LSB +: `MCP_NCH] = chActive;
						stD.rdat[`MCP_STAT_RUN] = running;
					end
					`MCP_ADR_DOUT: begin
						stD.rdat[`MCP_NCH-1:0] = stQ.doLevel;
					end
					default: begin
						stD.rdat = '0;
					end
				endcase
			end
		end
		if (busWrite) begin
			if (timeSel) begin
				tw[`MCP_HI_LSB +: `MCP_TW] = stQ.hiTime[timeIdx];
				tw[`MCP_LO_LSB +: `MCP_TW] = stQ.loTime[timeIdx];
				tw = laneMerge(tw, wb_dat_i, wb_sel_i);
				stD.hiTime[timeIdx] = timeClamp(tw[`MCP_HI_LSB +: `MCP_TW]);
				stD.loTime[timeIdx] = timeClamp(tw[`MCP_LO_LSB +: `MCP_TW]);
			end else if (wb_adr_i == `MCP_ADR_CTRL && wb_sel_i[0]) begin
				stD.pwmEn = wb_dat_i[`MCP_CTRL_PWM];
				stD.alarmEn = wb_dat_i[`MCP_CTRL_ALARM];
			end else if (wb_adr_i == `MCP_ADR_DOUT && wb_sel_i[0]) begin
				stD.doLevel = wb_dat_i[`MCP_NCH-1:0];
			end
		end
		// A new nonzero time value takes effect at the next phase change, so a period in flight is not cut short.
		for (int i = 0; i < `MCP_NCH; i++) begin
			if (!chActive[i]) begin
				stD.phase[i] = 1'b1;
				// Take a write of this cycle, so a woken channel opens with a full high phase.
				stD.cnt[i] = stD.hiTime[i];
			end else if (msTick) begin
				if (stQ.cnt[i] <= `MCP_TW'(1)) begin
					stD.phase[i] = ~stQ.phase[i];
					stD.cnt[i] = stQ.phase[i] ? stQ.loTime[i] : stQ.hiTime[i];
				end else begin
					stD.cnt[i] = stQ.cnt[i] - `MCP_TW'(1);
				end
			end
			stD.out[i] = chActive[i] ? stD.phase[i] : stQ.doLevel[i];
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stQ <= RST_STATE;
		end else begin
			stQ <= stD;
		end
	end

	assign wb_ack_o = stQ.ack;
	assign wb_dat_o = stQ.rdat;
	assign doOut = stQ.out;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	chk_rst_pwm_off: assert property ($past(sys_rst) |-> !stQ.pwmEn)
		else $error("PWM enable not off after reset");
	chk_rst_alarm_off: assert property ($past(sys_rst) |-> !stQ.alarmEn && !running)
		else $error("Alarm enable not off after reset");
	// While the alarm is armed and the watchdog has timed out, channel 0 must follow its sequencer.
	chk_alarm_drives_pwm: assert property (stQ.alarmEn && wdTimeout && stQ.hiTime[0] != '0
		&& stQ.loTime[0] != '0 |=> doOut[0] == $past(stD.phase[0]))
		else $error("Watchdog alarm did not run PWM");
	// Whatever switches PWM off, the lines fall back to the static levels on the next edge.
	chk_off_static: assert property (!running |=> doOut == $past(stQ.doLevel))
		else $error("Output not static while PWM is off");
	// A control write reaches the enable on the ack edge, so software sees the new mode at once.
	chk_ctrl_write: assert property (busWrite && !timeSel && wb_adr_i == `MCP_ADR_CTRL && wb_sel_i[0]
		|=> stQ.pwmEn == $past(wb_dat_i[`MCP_CTRL_PWM]))
		else $error("Control write did not reach the enable");
	// Writes of 1 to 4 are below the usable range and are stored as the minimum.
	chk_min_clamp: assert property (busWrite && timeSel && wb_sel_i[1:0] == 2'b11
		&& wb_dat_i[`MCP_HI_LSB +: `MCP_TW] != '0 && wb_dat_i[`MCP_HI_LSB +: `MCP_TW] < `MCP_TIME_MIN
		|=> stQ.hiTime[$past(timeIdx)] == `MCP_TIME_MIN)
		else $error("Short time not raised to minimum");
	// Zero is the per-channel off switch, so it must be stored as written and never clamped.
	chk_zero_kept: assert property (busWrite && timeSel && wb_sel_i[1:0] == 2'b11
		&& wb_dat_i[`MCP_HI_LSB +: `MCP_TW] == '0 |=> stQ.hiTime[$past(timeIdx)] == '0)
		else $error("Zero time not kept");

	genvar g;
	for (g = 0; g < `MCP_NCH; g++) begin : gChk
		// Reset loads the 1000 ms default into both times of every channel.
		chk_rst_times: assert property ($past(sys_rst) |-> stQ.hiTime[g] == `MCP_TIME_RST
			&& stQ.loTime[g] == `MCP_TIME_RST)
			else $error("Times not 1000 after reset");
		// Stored times are zero or inside the usable range; 1 to 4 would make a phase too short.
		chk_time_floor: assert property ((stQ.hiTime[g] == '0 || stQ.hiTime[g] >= `MCP_TIME_MIN)
			&& (stQ.loTime[g] == '0 || stQ.loTime[g] >= `MCP_TIME_MIN))
			else $error("Stored time below minimum");
		// A zero count on a live channel would flip the phase on the very next tick.
		chk_cnt_live: assert property (chActive[g] |-> stQ.cnt[g] != '0)
			else $error("Live channel has an empty counter");
		// Between phase changes each tick takes exactly one off the count.
		chk_high_hold: assert property (chActive[g] && msTick && stQ.cnt[g] > `MCP_TW'(1)
			&& $stable(running)
			|=> stQ.cnt[g] == $past(stQ.cnt[g]) - `MCP_TW'(1) && stQ.phase[g] == $past(stQ.phase[g]))
			else $error("Phase count did not step down");
		// At the last tick of a phase the line flips and the counter loads the other time.
		chk_phase_flip: assert property (chActive[g] && msTick && stQ.cnt[g] == `MCP_TW'(1)
			&& stQ.phase[g] |=> !doOut[g] && stQ.cnt[g] == $past(stQ.loTime[g]))
			else $error("High phase did not end into low time");
		chk_low_flip: assert property (chActive[g] && msTick && stQ.cnt[g] == `MCP_TW'(1)
			&& !stQ.phase[g] |=> doOut[g] && stQ.cnt[g] == $past(stQ.hiTime[g]))
			else $error("Low phase did not end into high time");
		// A channel that comes alive always opens with its high phase.
		chk_start_high: assert property (!chActive[g] ##1 chActive[g] |=> doOut[g])
			else $error("Channel did not start high");
		// A channel switched off by a zero time shows the static level, whatever the others do.
		chk_zero_idle: assert property ((stQ.hiTime[g] == '0 || stQ.loTime[g] == '0)
			|=> doOut[g] == $past(stQ.doLevel[g]))
			else $error("Disabled channel not at static level");
	end
endmodule // mcp_pwm_out

// ===== src/mcp_cfg.svh
// Constants for the multi-channel PWM output block.
`ifndef MCP_CFG_SVH
`define MCP_CFG_SVH
`define MCP_NCH 8
`define MCP_TW 16
`define MCP_ADR_CTRL 8'h00
`define MCP_ADR_STAT 8'h04
`define MCP_ADR_DOUT 8'h08
`define MCP_TIME_PAGE 3'h1
`define MCP_CTRL_PWM 0
`define MCP_CTRL_ALARM 1
`define MCP_HI_LSB 0
`define MCP_LO_LSB 16
`define MCP_STAT_ACT_LSB 8
`define MCP_STAT_RUN 16
`define MCP_TIME_RST 16'h03e8
`define MCP_TIME_MIN 16'h0005
`define MCP_CLK_NS 4
`define MCP_MS_NS 1000000
`define MCP_MS_CYCLES ((`MCP_MS_NS) / (`MCP_CLK_NS))
`endif

// ===== src/mcp_pkg.sv
// Types shared by the multi-channel PWM output block.
`include "mcp_cfg.svh"
package mcp_pkg;
	typedef logic [`MCP_TW-1:0] mcp_time_t;
	typedef logic [`MCP_NCH-1:0] mcp_chan_t;
	typedef struct packed {
		logic pwmEn;
		logic alarmEn;
		mcp_chan_t doLevel;
		mcp_time_t [`MCP_NCH-1:0] hiTime;
		mcp_time_t [`MCP_NCH-1:0] loTime;
		mcp_time_t [`MCP_NCH-1:0] cnt;
		mcp_chan_t phase;
		mcp_chan_t out;
		logic ack;
		logic [31:0] rdat;
	} mcp_state_t;
	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
	} mcp_div_t;
endpackage

// ===== src/mcp_tick_div.sv
// Millisecond tick divider: one-cycle enable pulse every CYCLES clocks.
`timescale 1ns/1ps
`include "mcp_cfg.svh"
module mcp_tick_div #(
	parameter int unsigned CYCLES = `MCP_MS_CYCLES
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	output logic tick
);
	import mcp_pkg::*;
	mcp_div_t stQ;
	mcp_div_t stD;
	localparam logic [31:0] LAST = 32'(CYCLES - 1);

	always_comb begin
		stD = stQ;
		stD.tick = (stQ.cnt == LAST);
		stD.cnt = stD.tick ? 32'h0 : stQ.cnt + 32'h1;
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stQ <= '0;
		end else begin
			stQ <= stD;
		end
	end

	assign tick = stQ.tick;
endmodule // mcp_tick_div

// ===== sim/mcp_load_model.sv
// Output load model that measures the length of each high and low run on one output line.
`timescale 1ns/1ps
module mcp_load_model (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic level,
	output logic [15:0] hiRun,
	output logic [15:0] loRun
);
	logic [15:0] run;
	logic last;
	// A load sees only levels, so run lengths are counted in clocks of the last completed phase.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			run <= 16'h0000;
			last <= 1'b0;
			hiRun <= 16'h0000;
			loRun <= 16'h0000;
		end else begin
			last <= level;
			if (level !== last) begin
				run <= 16'h0001;
				if (last)
					hiRun <= run;
				else
					loRun <= run;
			end else
				run <= run + 16'h0001;
		end
	end
endmodule // mcp_load_model

// ===== sim/mcp_pwm_out_test.sv
// Self-checking bench for the multi-channel PWM output block.
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin num_errors++; \
	$display("unexpected %s exp %h got %h", n, e, a); end end
module mcp_pwm_out_test;
	import mcp_pkg::*;
	logic core_clk = 0;
	logic sys_rst = 1;
	logic cyc = 0, stb = 0, we = 0, wd = 0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0, rdat, q;
	logic ack;
	mcp_chan_t doOut;
	logic [15:0] hi0, lo0;
	int num_errors = 0, checked = 0, cycles = 0;
	always #2 core_clk = ~core_clk;
	mcp_pwm_out #(.TICK_CYCLES(4)) uut (.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.wdTimeout(wd), .doOut(doOut));
	mcp_load_model load0 (.core_clk(core_clk), .sys_rst(sys_rst), .level(doOut[0]), .hiRun(hi0), .loRun(lo0));
	task automatic results();
		if (num_errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// The run is a few hundred clocks; the 20000-cycle limit only trips on a stuck handshake.
	always @(posedge core_clk) begin
		cycles++;
		if (cycles > 20000) begin
			num_errors++;
			results();
		end
	end
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge core_clk); while (ack !== 1'b1);
		q = rdat;
		cyc <= 0;
		stb <= 0;
	endtask
	task automatic test_reset();
		wb(0, 8'h00, 0);
		`CHK("ctrl", 32'h0, q)
		for (int c = 0; c < 8; c++) begin
			wb(0, 8'h20 + 8'(4 * c), 0);
			`CHK("times", 32'h03e803e8, q)
		end
		`CHK("dout", 8'h00, doOut)
	endtask
	task automatic test_pwm();
		wb(1, 8'h08, 32'h2);
		wb(1, 8'h20, 32'h00070005);
		wb(1, 8'h24, 32'h00050000);
		wb(1, 8'h28, 32'h00000003);
		wb(0, 8'h28, 0);
		`CHK("min time", 32'h00000005, q)
		wb(1, 8'h00, 32'h1);
		repeat (200) @(posedge core_clk);
		`CHK("high run", 16'd20, hi0)
		`CHK("low run", 16'd28, lo0)
		`CHK("off chan", 1'b1, doOut[1])
		wb(0, 8'h04, 0);
		`CHK("status", 9'h1f9, q[16:8])
	endtask
	task automatic test_alarm();
		wb(1, 8'h00, 32'h2);
		wb(0, 8'h04, 0);
		`CHK("idle", 1'b0, q[16])
		@(posedge core_clk);
		wd <= 1;
		wb(0, 8'h04, 0);
		`CHK("alarm run", 1'b1, q[16])
		`CHK("alarm chan", 1'b1, q[8])
		wd <= 0;
	endtask
	initial begin
		repeat (16) @(posedge core_clk);
		sys_rst <= 0;
		test_reset();
		test_pwm();
		test_alarm();
		results();
	end
endmodule // mcp_pwm_out_test
